// [verilog/reset_watchdog_pkg.sv]
/*
 * Package for the reset and watchdog unit: register offset, field layout,
 * reset values, timing counts and shared types.
 * Assumes a single 40 MHz clock and a plain strobe-based register port.
 */
package reset_watchdog_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] WDOG_OFFSET      = 8'hD8;
    localparam logic [7:0] WDOG_RESET_VALUE = 8'hFE;
    localparam int         ACTIVE_BIT       = 0;
    localparam int         SOFT_RESET_BIT   = 1;
    localparam int         COUNT_FIELD_LO   = 2;
    localparam int         COUNT_FIELD_HI   = 7;
    localparam logic [7:0] UNMAPPED_READ    = 8'h00;

    // ----------------------------------------------------------------
    // timing and core values
    // ----------------------------------------------------------------
    localparam int          CLOCK_MHZ        = 40;
    localparam int          STRETCH_CYCLES   = 2048;
    localparam int          STRETCH_WIDTH    = 12;
    localparam int          PRESCALE_DIVIDE  = 12;
    localparam logic [3:0]  PRESCALE_LAST    = 4'(PRESCALE_DIVIDE - 1);
    localparam logic [11:0] STRETCH_LAST     =
        12'(STRETCH_CYCLES - 1);
    localparam logic [11:0] RESET_VECTOR     = 12'hFFE;

    // ----------------------------------------------------------------
    // shared types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_WAIT,
        MODE_STOP
    } power_mode_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_type;

    typedef struct packed {
        logic       hardwareActivation;
        logic       pinGatedStop;
    } chip_option_type;

    typedef struct packed {
        logic        coreResetActive;
        logic        ioPullupInputs;
        logic        oscRestart;
        logic        stackClear;
        logic        nmiModeSet;
        logic [11:0] pcLoad;
    } reset_ctrl_type;

endpackage : reset_watchdog_pkg

// [verilog/reset_stretcher.sv]
/*
 * Reset stretcher: merges reset sources and holds the internal reset
 * for a fixed count after all sources are gone.
 * Assumes sources are synchronous levels or pulses on mclk.
 */
`timescale 1ns/1ps
module reset_stretcher
(
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst_b,
    // sources
    input  wire logic pinResetLow,
    input  wire logic watchdogFire,
    // result
    output logic      internalReset
);
    import reset_watchdog_pkg::*;

    logic [11:0] holdCount_reg;
    logic        anySource;

    // ----------------------------------------------------------------
    // source merge
    // ----------------------------------------------------------------
    assign anySource = pinResetLow | watchdogFire;

    // power-on (rst_b) and sources restart the count; a one-cycle pulse
    // still yields the full hold, so short pin glitches are complete
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            holdCount_reg <= 12'h000;
            internalReset <= 1'b1;
        end
        else if (anySource)
        begin
            holdCount_reg <= 12'h000;
            internalReset <= 1'b1;
        end
        else if (internalReset)
        begin
            if (holdCount_reg == STRETCH_LAST)
                internalReset <= 1'b0;
            else
                holdCount_reg <= holdCount_reg + 12'h001;
        end
    end

    a_stretch_hold : assert property (@(posedge mclk) disable iff (!rst_b)
        $fell(anySource) |-> internalReset [*8])
        else $error("reset released too early");
    a_source_holds : assert property (@(posedge mclk) disable iff (!rst_b)
        anySource |=> internalReset)
        else $error("reset not held by source");

endmodule : reset_stretcher

// [verilog/watchdog_prescaler.sv]
/*
 * Divide-by-twelve tick generator for the watchdog counter.
 * Assumes clear restarts the phase so a reload counts a full period.
 */
`timescale 1ns/1ps
module watchdog_prescaler
(
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst_b,
    // control
    input  wire logic clear,
    input  wire logic hold,
    // output
    output logic      tick
);
    import reset_watchdog_pkg::*;

    logic [3:0] phase_reg;

    // ----------------------------------------------------------------
    // divider
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            phase_reg <= 4'h0;
            tick      <= 1'b0;
        end
        else if (clear)
        begin
            phase_reg <= 4'h0;
            tick      <= 1'b0;
        end
        else if (hold)
            tick <= 1'b0;               // frozen while stopped
        else if (phase_reg == PRESCALE_LAST)
        begin
            phase_reg <= 4'h0;
            tick      <= 1'b1;
        end
        else
        begin
            phase_reg <= phase_reg + 4'h1;
            tick      <= 1'b0;
        end
    end

    a_tick_spacing : assert property (@(posedge mclk) disable iff (!rst_b)
        tick |=> !tick [*8])
        else $error("ticks too close");

endmodule : watchdog_prescaler

// [verilog/reset_and_watchdog_unit.sv]
/*
 * Reset generation and digital watchdog: merges pin, power-on and
 * watchdog reset, stretches it, drives core reset controls, and holds
 * the watchdog register and downcounter.
 * Assumes a synchronous reset pin, a core that reports stop/wait
 * requests and interrupt wake, and chip options as static inputs.
 */
`timescale 1ns/1ps
module reset_and_watchdog_unit
(
    // clock and power-on reset
    input  wire logic                              mclk,
    input  wire logic                              rst_b,
    // external pins
    input  wire logic                              resetPin_b,
    input  wire logic                              nmiPin,
    // chip options
    input  wire reset_watchdog_pkg::chip_option_type options,
    // register port
    input  wire reset_watchdog_pkg::reg_req_type   regReq,
    output logic [7:0]                             regRdata,
    // core power control
    input  wire logic                              stopRequest,
    input  wire logic                              waitRequest,
    input  wire logic                              wakeInterrupt,
    input  wire logic                              returnFromInterrupt,
    output reset_watchdog_pkg::power_mode_type     powerMode,
    output logic                                   stopAllowed,
    // core reset controls
    output reset_watchdog_pkg::reset_ctrl_type     resetCtrl,
    output logic                                   nmiMode
);
    import reset_watchdog_pkg::*;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [6:0] counter_reg;
    logic       active_reg;
    logic       internalReset;
    logic       watchdogFire_reg;
    logic       tick;
    logic       regWrite;
    logic       regRead;
    logic       frozen;
    logic       activeNow;
    logic       stopGranted;
    logic [6:0] counterNext;
    logic [7:0] regView;

    // reversed mapping between register field and counter bits
    function automatic logic [5:0] reverse6(input logic [5:0] v);
        logic [5:0] r;
        r = 6'h00;
        for (int i = 0; i < 6; i++)
            r[i] = v[5 - i];
        return r;
    endfunction : reverse6

    assign regWrite  = regReq.wr && (regReq.addr == WDOG_OFFSET);
    assign regRead   = regReq.rd;
    assign activeNow = active_reg | options.hardwareActivation;

    // ----------------------------------------------------------------
    // reset merge and stretch
    // ----------------------------------------------------------------
    reset_stretcher stretch_inst
    (
        .mclk          (mclk),
        .rst_b         (rst_b),
        .pinResetLow   (!resetPin_b),
        .watchdogFire  (watchdogFire_reg),
        .internalReset (internalReset)
    );

    // ----------------------------------------------------------------
    // prescaler
    // ----------------------------------------------------------------
    watchdog_prescaler prescale_inst
    (
        .mclk  (mclk),
        .rst_b (rst_b),
        .clear (internalReset | regWrite),
        .hold  (frozen),
        .tick  (tick)
    );

    // ----------------------------------------------------------------
    // stop gating
    // ----------------------------------------------------------------
    // stop only when no live watchdog, or when the nmi pin permits it
    always_comb
    begin
        if (!activeNow)
            stopGranted = 1'b1;
        else if (options.pinGatedStop)
            stopGranted = nmiPin;
        else
            stopGranted = 1'b0;
    end

    // power mode: stop degrades to wait when not granted
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            powerMode <= MODE_RUN;
        else if (internalReset)
            powerMode <= MODE_RUN;
        else
        begin
            unique case (powerMode)
                MODE_RUN:
                    if (stopRequest)
                        powerMode <= stopGranted ? MODE_STOP
                                                 : MODE_WAIT;
                    else if (waitRequest)
                        powerMode <= MODE_WAIT;
                MODE_WAIT:
                    if (wakeInterrupt)
                        powerMode <= MODE_RUN;
                MODE_STOP:
                    if (wakeInterrupt)
                        powerMode <= MODE_RUN;
                default:
                    powerMode <= MODE_RUN;
            endcase
        end
    end

    assign frozen = (powerMode == MODE_STOP);

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            stopAllowed <= 1'b0;
        else
            stopAllowed <= stopGranted;
    end

    // ----------------------------------------------------------------
    // watchdog register and downcounter
    // ----------------------------------------------------------------
    always_comb
    begin
        counterNext = counter_reg - 7'h01;
        if (regWrite)
            counterNext = {regReq.wdata[SOFT_RESET_BIT],
                           reverse6(regReq.wdata[COUNT_FIELD_HI:
                                                 COUNT_FIELD_LO])};
        else if (!tick)
            counterNext = counter_reg;
    end

    // counter reset is taken from the internal reset too
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            counter_reg <= {WDOG_RESET_VALUE[SOFT_RESET_BIT],
                            reverse6(WDOG_RESET_VALUE[COUNT_FIELD_HI:
                                                      COUNT_FIELD_LO])};
        else if (internalReset)
            counter_reg <= {WDOG_RESET_VALUE[SOFT_RESET_BIT],
                            reverse6(WDOG_RESET_VALUE[COUNT_FIELD_HI:
                                                      COUNT_FIELD_LO])};
        else
            counter_reg <= counterNext;
    end

    // activation is sticky: only a reset clears it
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            active_reg <= WDOG_RESET_VALUE[ACTIVE_BIT];
        else if (internalReset)
            active_reg <= WDOG_RESET_VALUE[ACTIVE_BIT];
        else if (regWrite && regReq.wdata[ACTIVE_BIT])
            active_reg <= 1'b1;
    end

    // fire while active when bit 6 falls or on software-reset clear
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            watchdogFire_reg <= 1'b0;
        else if (internalReset)
            watchdogFire_reg <= 1'b0;
        else
            watchdogFire_reg <= activeNow
                && ((counter_reg[6] && !counterNext[6])
                    || (regWrite
                        && !regReq.wdata[SOFT_RESET_BIT]));
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    assign regView = {reverse6(counter_reg[5:0]), counter_reg[6],
                      activeNow};

    // data stand the cycle after the strobe; unmapped reads as zero
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            regRdata <= UNMAPPED_READ;
        else if (regRead && regReq.addr == WDOG_OFFSET)
            regRdata <= regView;
        else
            regRdata <= UNMAPPED_READ;
    end

    // ----------------------------------------------------------------
    // core reset controls
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            resetCtrl <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, RESET_VECTOR};
        else
        begin
            resetCtrl.coreResetActive <= internalReset;
            resetCtrl.ioPullupInputs  <= internalReset;
            resetCtrl.oscRestart      <= internalReset;
            resetCtrl.stackClear      <= internalReset;
            resetCtrl.nmiModeSet      <= internalReset;
            resetCtrl.pcLoad          <= RESET_VECTOR;
        end
    end

    // nonmaskable mode until the first return from interrupt
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            nmiMode <= 1'b1;
        else if (internalReset)
            nmiMode <= 1'b1;
        else if (returnFromInterrupt)
            nmiMode <= 1'b0;
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_pin_holds_reset : assert property (@(posedge mclk) disable iff (!rst_b)
        !resetPin_b |=> ##1 resetCtrl.coreResetActive)
        else $error("pin low did not hold reset");
    a_soft_reset_fires : assert property (@(posedge mclk)
        disable iff (!rst_b)
        regWrite && activeNow && !regReq.wdata[SOFT_RESET_BIT]
            && !internalReset |=> watchdogFire_reg)
        else $error("software reset bit clear did not fire");
    a_active_sticky : assert property (@(posedge mclk) disable iff (!rst_b)
        active_reg && !internalReset |=> active_reg)
        else $error("activation dropped without reset");
    a_inactive_silent : assert property (@(posedge mclk)
        disable iff (!rst_b)
        !activeNow |=> !watchdogFire_reg)
        else $error("inactive watchdog fired");
    a_freeze_in_stop : assert property (@(posedge mclk)
        disable iff (!rst_b)
        frozen && $past(frozen) && !regWrite && !internalReset
            |=> counter_reg == $past(counter_reg))
        else $error("counter moved while stopped");
    a_hw_no_stop : assert property (@(posedge mclk) disable iff (!rst_b)
        options.hardwareActivation && !options.pinGatedStop
            |-> !stopGranted)
        else $error("stop granted with hardware watchdog");
    a_fire_resets : assert property (@(posedge mclk) disable iff (!rst_b)
        watchdogFire_reg |=> ##1 resetCtrl.coreResetActive
            && resetCtrl.pcLoad == RESET_VECTOR)
        else $error("timeout did not reset core");
    a_reset_nmi_mode : assert property (@(posedge mclk)
        disable iff (!rst_b)
        internalReset |=> nmiMode)
        else $error("reset did not set nmi mode");
    a_write_loads : assert property (@(posedge mclk) disable iff (!rst_b)
        regWrite && !internalReset
            |=> counter_reg[5:0] == reverse6($past(regReq.wdata[7:2])))
        else $error("write did not load counter");
    a_reset_value : assert property (@(posedge mclk) disable iff (!rst_b)
        $fell(internalReset)
            |-> {regView[7:1], active_reg} == WDOG_RESET_VALUE)
        else $error("register reset value wrong");

    c_timeout   : cover property (@(posedge mclk) watchdogFire_reg);
    c_stop_wake : cover property (@(posedge mclk)
        frozen ##1 !frozen);
    c_activate  : cover property (@(posedge mclk) $rose(active_reg));
    c_pin_reset : cover property (@(posedge mclk) $fell(resetPin_b));

endmodule : reset_and_watchdog_unit

// [test/reset_supervisor_model.sv]
/*
 * Far-side model: external reset circuit, the nmi line with its pull-up
 * and open-drain pull-down, and supervising software on the register port.
 * Assumes callers start its tasks just after a rising edge of mclk.
 */
`timescale 1ns/1ps
module reset_supervisor_model
(
    // clock
    input  wire logic                        mclk,
    // board and software control
    input  wire logic                        kickOn,
    input  wire logic                        nmiHoldLow,
    // towards the unit
    input  wire logic [7:0]                  regRdata,
    output logic                             resetPin_b,
    output logic                             nmiPin,
    output reset_watchdog_pkg::reg_req_type  regReq
);
    import reset_watchdog_pkg::*;

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    // port line pulls low when held, pull-up otherwise
    assign nmiPin = nmiHoldLow ? 1'b0 : 1'b1;

    // idle levels from time zero
    initial
    begin
        resetPin_b = 1'b1;
        regReq     = '0;
    end

    // ------------------------------------------------------------
    // bus cycles and reset pulses
    // ------------------------------------------------------------
    task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
        regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        regReq.wr <= 1'b0;
    endtask : bus_write

    task automatic bus_read(input logic [7:0] a, output logic [7:0] d);
        regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        regReq.rd <= 1'b0;
        #1 d = regRdata;
    endtask : bus_read

    task automatic pin_low(input int cycles);
        resetPin_b <= 1'b0;
        repeat (cycles) @(posedge mclk);
        resetPin_b <= 1'b1;
    endtask : pin_low

    // periodic reload; the software-reset bit is always written high
    always
    begin
        @(posedge mclk);
        if (kickOn)
        begin
            repeat (300) @(posedge mclk);
            if (kickOn)
                bus_write(WDOG_OFFSET, 8'hFF);
        end
    end
endmodule : reset_supervisor_model

// [test/reset_and_watchdog_unit_bench.sv]
/*
 * Self-checking bench for the reset and watchdog unit.
 * Assumes the far-side model in reset_supervisor_model.
 */
`timescale 1ns/1ps
module reset_and_watchdog_unit_bench;
    import reset_watchdog_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic            mclk;
    logic            rst_b;
    logic            kickOn;
    logic            nmiHoldLow;
    logic [3:0]      pulses;
    chip_option_type options;
    logic            resetPin_b;
    logic            nmiPin;
    reg_req_type     regReq;
    logic [7:0]      regRdata;
    power_mode_type  powerMode;
    logic            stopAllowed;
    reset_ctrl_type  resetCtrl;
    logic            nmiMode;
    int              badCount;
    int              comparisons;
    int              n;
    logic [23:0]     rows [5];
    logic [15:0]     fires [3];

    // 40 MHz clock
    initial mclk = 1'b0;
    always #12.5 mclk = ~mclk;

    reset_and_watchdog_unit i_dut
    (
        .mclk(mclk), .rst_b(rst_b), .resetPin_b(resetPin_b),
        .nmiPin(nmiPin), .options(options), .regReq(regReq),
        .regRdata(regRdata), .stopRequest(pulses[0]),
        .waitRequest(pulses[1]), .wakeInterrupt(pulses[2]),
        .returnFromInterrupt(pulses[3]), .powerMode(powerMode),
        .stopAllowed(stopAllowed), .resetCtrl(resetCtrl),
        .nmiMode(nmiMode)
    );

    reset_supervisor_model u_partner
    (
        .mclk(mclk), .kickOn(kickOn), .nmiHoldLow(nmiHoldLow),
        .regRdata(regRdata), .resetPin_b(resetPin_b), .nmiPin(nmiPin),
        .regReq(regReq)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [16:0] seen, input logic [16:0] want);
        comparisons++;
        if (seen !== want)
        begin
            badCount++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask : check

    task automatic near(input int cnt, input int want, input int tol);
        check({16'h0000, cnt >= want - tol && cnt <= want + tol}, 17'h1);
    endtask : near

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        u_partner.bus_write(a, d);
    endtask : reg_write

    task automatic reg_expect(input logic [7:0] a, input logic [7:0] want);
        logic [7:0] d;
        @(posedge mclk);
        u_partner.bus_read(a, d);
        check({9'h000, d}, {9'h000, want});
    endtask : reg_expect

    // one-cycle pulse: 0 stop, 1 wait, 2 wake, 3 return
    task automatic pulse(input int idx);
        @(posedge mclk);
        pulses[idx] <= 1'b1;
        @(posedge mclk);
        pulses <= 4'h0;
        @(negedge mclk);
    endtask : pulse

    task automatic mode_is(input power_mode_type m);
        check({15'h0000, powerMode}, {15'h0000, m});
    endtask : mode_is

    task automatic wait_core(input logic lvl, input int lim, output int c);
        c = 0;
        while (resetCtrl.coreResetActive !== lvl && c < lim)
        begin
            @(negedge mclk);
            c++;
        end
    endtask : wait_core

    task automatic do_reset(input logic hw, input logic gated);
        @(posedge mclk);
        options <= '{hw, gated};
        rst_b   <= 1'b0;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        check(resetCtrl, {5'h1F, RESET_VECTOR});
        check({13'h0000, nmiMode, powerMode, stopAllowed},
              {13'h0000, 1'b1, MODE_RUN, 1'b0});
        @(posedge mclk);
        rst_b <= 1'b1;
        wait_core(1'b0, 3000, n);
        near(n, STRETCH_CYCLES + 1, 3);
    endtask : do_reset

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, badCount);
        if (badCount == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude

    // hang guard, well beyond the planned run
    initial
    begin
        #(25 * 60000);
        badCount++;
        conclude();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        rst_b = 1'b0;
        kickOn = 1'b0;
        nmiHoldLow = 1'b0;
        pulses = 4'h0;
        options = '0;
        badCount = 0;
        comparisons = 0;
        rows = '{24'hD8FEFE, 24'hD80202, 24'hD88080, 24'hD8FCFC, 24'hD97C00};
        fires = '{16'h0301, 16'h0721, 16'hFF40};
        do_reset(1'b0, 1'b0);
        reg_expect(WDOG_OFFSET, WDOG_RESET_VALUE);
        for (int i = 0; i < 5; i++)
        begin
            reg_write(rows[i][23:16], rows[i][15:8]);
            reg_expect(rows[i][23:16], rows[i][7:0]);
            check({16'h0000, resetCtrl.coreResetActive}, 17'h0);
        end
        reg_write(WDOG_OFFSET, 8'h82);
        repeat (14) @(posedge mclk);
        reg_expect(WDOG_OFFSET, 8'h02);
        $display("register and timer test done");
        // stop freezes the free timer, wake resumes it
        reg_write(WDOG_OFFSET, 8'h02);
        pulse(0);
        mode_is(MODE_STOP);
        check({16'h0000, stopAllowed}, 17'h1);
        repeat (40) @(posedge mclk);
        reg_expect(WDOG_OFFSET, 8'h02);
        pulse(2);
        mode_is(MODE_RUN);
        repeat (12) @(posedge mclk);
        reg_expect(WDOG_OFFSET, 8'hFC);
        pulse(3);
        check({16'h0000, nmiMode}, 17'h0);
        // activation is sticky, clearing the software-reset bit fires
        reg_write(WDOG_OFFSET, 8'hFF);
        reg_write(WDOG_OFFSET, 8'hFE);
        reg_expect(WDOG_OFFSET, 8'hFF);
        reg_write(WDOG_OFFSET, 8'hFD);
        wait_core(1'b1, 10, n);
        near(n, 3, 2);
        wait_core(1'b0, 3000, n);
        near(n, STRETCH_CYCLES, 3);
        check({16'h0000, nmiMode}, 17'h1);
        reg_expect(WDOG_OFFSET, WDOG_RESET_VALUE);
        $display("software watchdog test done");
        // short pin pulse while stopped
        pulse(0);
        @(posedge mclk);
        u_partner.pin_low(1);
        wait_core(1'b1, 10, n);
        near(n, 3, 2);
        check({14'h0000, resetCtrl.ioPullupInputs, resetCtrl.oscRestart,
               resetCtrl.stackClear}, 17'h7);
        wait_core(1'b0, 3000, n);
        near(n, STRETCH_CYCLES, 3);
        mode_is(MODE_RUN);
        // long pin hold keeps the core in reset throughout
        @(posedge mclk);
        fork
            u_partner.pin_low(3000);
            begin
                repeat (2990) @(negedge mclk);
                check({16'h0000, resetCtrl.coreResetActive}, 17'h1);
            end
        join
        wait_core(1'b0, 3000, n);
        near(n, STRETCH_CYCLES + 2, 3);
        $display("pin reset test done");
        // hardware activation: forced bit, stop as wait, reload, timeouts
        do_reset(1'b1, 1'b0);
        reg_expect(WDOG_OFFSET, 8'hFF);
        reg_write(WDOG_OFFSET, 8'hFE);
        reg_expect(WDOG_OFFSET, 8'hFF);
        pulse(1);
        mode_is(MODE_WAIT);
        check({16'h0000, stopAllowed}, 17'h0);
        pulse(2);
        @(posedge mclk);
        kickOn <= 1'b1;
        repeat (2000) @(negedge mclk);
        check({16'h0000, resetCtrl.coreResetActive}, 17'h0);
        @(posedge mclk);
        kickOn <= 1'b0;
        repeat (3) @(posedge mclk);
        for (int i = 0; i < 3; i++)
        begin
            pulse(0);
            mode_is(MODE_WAIT);
            reg_write(WDOG_OFFSET, fires[i][15:8]);
            wait_core(1'b1, 1000, n);
            near(n, int'(fires[i][7:0]) * PRESCALE_DIVIDE + 4, 3);
            wait_core(1'b0, 3000, n);
            near(n, STRETCH_CYCLES, 3);
        end
        $display("hardware watchdog test done");
        // pin-gated stop: low pin gives wait, high pin freezes in stop
        do_reset(1'b1, 1'b1);
        @(posedge mclk);
        nmiHoldLow <= 1'b1;
        pulse(0);
        mode_is(MODE_WAIT);
        check({16'h0000, stopAllowed}, 17'h0);
        pulse(2);
        @(posedge mclk);
        nmiHoldLow <= 1'b0;
        reg_write(WDOG_OFFSET, 8'hFF);
        pulse(0);
        mode_is(MODE_STOP);
        check({16'h0000, stopAllowed}, 17'h1);
        repeat (900) @(negedge mclk);
        check({16'h0000, resetCtrl.coreResetActive}, 17'h0);
        pulse(2);
        wait_core(1'b1, 1000, n);
        near(n, 64 * PRESCALE_DIVIDE, 8);
        $display("gated stop test done");
        conclude();
    end
endmodule : reset_and_watchdog_unit_bench
